// file: design/motor_overload_pkg.sv
`default_nettype none
package motor_overload_pkg;
  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CUR_W  = 16;
  localparam int ACC_W  = 32;

  // --------------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_MAX_CURRENT   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RATED_CURRENT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PEAK_PERMILLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PEAK_TIME     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SUBMODE       = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_THRESHOLD     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ACCUM         = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_APPLIED       = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS        = 8'h20;

  // --------------------------------------------------------------------
  // Fields and reset values
  // --------------------------------------------------------------------
  localparam int                CLOSED_LOOP_BIT   = 0;
  localparam logic [CUR_W-1:0]  RST_MAX_CURRENT   = 16'h0000;
  localparam logic [CUR_W-1:0]  RST_RATED_CURRENT = 16'h0000;
  localparam logic [CUR_W-1:0]  RST_PEAK_PERMILLE = 16'h0000;
  localparam logic [CUR_W-1:0]  RST_PEAK_TIME     = 16'h0000;
  localparam logic              RST_CLOSED_LOOP   = 1'b0;

  // --------------------------------------------------------------------
  // Scaling and timing
  // --------------------------------------------------------------------
  localparam logic [31:0] PERMILLE_DIV    = 32'h0000_03E8;
  localparam logic [31:0] MS_PER_S        = 32'h0000_03E8;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_PERIOD_NS  = 1000000;
  localparam int          TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // --------------------------------------------------------------------
  // Limiter states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_PEAK  = 3'b010,
    ST_RATED = 3'b100
  } limit_state_type;
endpackage
`default_nettype wire

// file: design/motor_overload_current_limiter.sv
// Function
// [RL1] Rated and absolute maximum motor current are configured in milliamperes.
// [RL2] Peak current setting is tenths of a percent of the rated current.
// [RL3] Peak time allowance is configured in milliseconds.
// [RL4] Readable threshold in milliampere-seconds chooses peak or rated limit.
// [RL5] Accumulated load value is readable and compared with the threshold.
// [RL6] The currently applied current limit is readable.
// [RL7] Status reads 0 when limiting inactive, 1 when active.
// [RL8] Limiting works only with the closed-loop bit 0 of submode set.
// [RL9] Active only if peak exceeds rated and a peak time is given.
// [RL10] Load limit derives from rated current, peak current and peak time.
// [RL11] Peak allowed until load reaches limit, then limit drops to rated.
// [RL12] Applied peak current never exceeds the absolute maximum current.
// [RL13] Accumulated load carries over between episodes, so limit comes sooner.
// [RL14] Below rated current load decays; under threshold peak limit returns.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`default_nettype none
module motor_overload_current_limiter
  import motor_overload_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  input  wire logic [CUR_W-1:0]  meas_current,
  output logic      [DATA_W-1:0] rdata,
  output logic      [CUR_W-1:0]  applied_current_limit,
  output logic                   limiting_active
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [CUR_W-1:0] clip_cur(input logic [31:0]      v,
                                                input logic [CUR_W-1:0] lim);
    clip_cur = (v > {16'h0000, lim}) ? lim : v[CUR_W-1:0];
  endfunction

  logic [CUR_W-1:0]  max_cur_q;
  logic [CUR_W-1:0]  rated_q;
  logic [CUR_W-1:0]  peak_pm_q;
  logic [CUR_W-1:0]  peak_time_allowance_q;
  logic              closed_loop_q;
  logic [CUR_W-1:0]  peak_cur_q;
  logic [CUR_W-1:0]  rated_eff_q;
  logic [ACC_W-1:0]  thermal_load_limit_q;
  logic [ACC_W-1:0]  threshold_mas_q;
  logic              enable_q;
  logic [31:0]       tick_cnt_q;
  logic              tick_q;
  logic [ACC_W-1:0]  accumulated_load_value_q;
  logic [ACC_W-1:0]  acc_d;
  limit_state_type   state_q;
  logic [31:0]       peak_raw;
  logic [CUR_W-1:0]  excess;
  logic [DATA_W-1:0] rdata_d;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      max_cur_q             <= RST_MAX_CURRENT;
      rated_q               <= RST_RATED_CURRENT;
      peak_pm_q             <= RST_PEAK_PERMILLE;
      peak_time_allowance_q <= RST_PEAK_TIME;
      closed_loop_q         <= RST_CLOSED_LOOP;
    end else if (ce && wr) begin
      case (addr)
        OFF_MAX_CURRENT:   max_cur_q <= wdata[CUR_W-1:0];             // see [RL1]
        OFF_RATED_CURRENT: rated_q <= wdata[CUR_W-1:0];               // see [RL1]
        OFF_PEAK_PERMILLE: peak_pm_q <= wdata[CUR_W-1:0];             // see [RL2]
        OFF_PEAK_TIME:     peak_time_allowance_q <= wdata[CUR_W-1:0]; // see [RL3]
        OFF_SUBMODE:       closed_loop_q <= wdata[CLOSED_LOOP_BIT];    // see [RL8]
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Derived limits
  // --------------------------------------------------------------------
  assign peak_raw = (32'(rated_q) * 32'(peak_pm_q)) / PERMILLE_DIV; // see [RL2]
  assign excess   = peak_cur_q - rated_eff_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peak_cur_q           <= '0;
      rated_eff_q          <= '0;
      thermal_load_limit_q <= '0;
      threshold_mas_q      <= '0;
      enable_q             <= 1'b0;
    end else if (ce) begin
      peak_cur_q  <= clip_cur(peak_raw, max_cur_q);         // see [RL12]
      rated_eff_q <= clip_cur(32'(rated_q), max_cur_q);     // see [RL12]
      enable_q    <= closed_loop_q && (peak_cur_q > rated_eff_q)
                     && (peak_time_allowance_q != '0);      // see [RL8] [RL9]
      // Limit in mA*ms: excess current over the peak time allowance
      thermal_load_limit_q <= (peak_cur_q > rated_eff_q) ?
        32'(32'(excess) * 32'(peak_time_allowance_q)) : '0; // see [RL10]
      threshold_mas_q <= thermal_load_limit_q / MS_PER_S;   // see [RL4]
    end
  end

  // --------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce) begin
      tick_q     <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // --------------------------------------------------------------------
  // Load accumulator, saturating at 0 and at the limit
  // --------------------------------------------------------------------
  always_comb begin
    logic [ACC_W:0] sum;
    sum   = '0;
    acc_d = accumulated_load_value_q;
    if (!enable_q) begin
      acc_d = '0;
    end else if (tick_q && meas_current > rated_eff_q) begin
      sum   = {1'b0, accumulated_load_value_q} + 33'(meas_current - rated_eff_q);
      acc_d = (sum > {1'b0, thermal_load_limit_q}) ? thermal_load_limit_q
                                                   : sum[ACC_W-1:0]; // see [RL13]
    end else if (tick_q) begin
      acc_d = (accumulated_load_value_q > 32'(rated_eff_q - meas_current)) ?
              accumulated_load_value_q - 32'(rated_eff_q - meas_current) : '0; // see [RL14]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accumulated_load_value_q <= '0;
    end else if (ce) begin
      accumulated_load_value_q <= acc_d; // see [RL5]
    end
  end

  // --------------------------------------------------------------------
  // Limiter state
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_OFF;
    end else if (ce) begin
      if (!enable_q) begin
        state_q <= ST_OFF; // see [RL9]
      end else begin
        case (state_q)
          ST_OFF:   state_q <= ST_PEAK;
          ST_PEAK:  if (accumulated_load_value_q >= thermal_load_limit_q) begin
            state_q <= ST_RATED; // see [RL5] [RL11]
          end
          ST_RATED: if (accumulated_load_value_q < thermal_load_limit_q) begin
            state_q <= ST_PEAK; // see [RL14]
          end
          default:  state_q <= ST_OFF;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs to the current loop
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      applied_current_limit <= '0;
      limiting_active       <= 1'b0;
    end else if (ce) begin
      limiting_active <= (state_q != ST_OFF); // see [RL7]
      case (state_q)
        ST_RATED: applied_current_limit <= rated_eff_q; // see [RL11]
        ST_PEAK:  applied_current_limit <= peak_cur_q;  // see [RL12]
        default:  applied_current_limit <= (peak_cur_q > rated_eff_q) ? peak_cur_q
                                                                      : rated_eff_q;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    case (addr)
      OFF_MAX_CURRENT:   rdata_d = 32'(max_cur_q);
      OFF_RATED_CURRENT: rdata_d = 32'(rated_q);
      OFF_PEAK_PERMILLE: rdata_d = 32'(peak_pm_q);
      OFF_PEAK_TIME:     rdata_d = 32'(peak_time_allowance_q);
      OFF_SUBMODE:       rdata_d = 32'(closed_loop_q);
      OFF_THRESHOLD:     rdata_d = threshold_mas_q;          // see [RL4]
      OFF_ACCUM:         rdata_d = accumulated_load_value_q; // see [RL5]
      OFF_APPLIED:       rdata_d = 32'(applied_current_limit); // see [RL6]
      OFF_STATUS:        rdata_d = 32'(limiting_active);     // see [RL7]
      default:           rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= rd ? rdata_d : '0;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_reach;
    ce && enable_q && state_q == ST_PEAK && accumulated_load_value_q >= thermal_load_limit_q;
  endsequence

  sequence s_cut;
    ce && state_q == ST_RATED;
  endsequence

  property p_status_read;
    ce && rd && addr == OFF_STATUS |=> rdata == 32'($past(limiting_active));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // see [RL7]

  // Second step only binds when the enable ran on the cycle before
  property p_closed_loop_needed;
    ce && !closed_loop_q |=> !enable_q ##1 (!$past(ce) || state_q == ST_OFF);
  endproperty
  a_closed_loop_needed: assert property (p_closed_loop_needed) // see [RL8]
    else $error("limiter active without closed loop");

  property p_peak_not_above_rated;
    ce && peak_cur_q <= rated_eff_q |=> !enable_q;
  endproperty
  a_peak_not_above_rated: assert property (p_peak_not_above_rated) // see [RL9]
    else $error("enabled although peak not above rated");

  property p_off_when_disabled;
    ce && !enable_q |=> state_q == ST_OFF;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) // see [RL9]
    else $error("state not off when disabled");

  property p_reach_cuts;
    s_reach |=> s_cut |=> applied_current_limit == $past(rated_eff_q);
  endproperty
  a_reach_cuts: assert property (p_reach_cuts) // see [RL11]
    else $error("limit not cut to rated");

  property p_max_clip;
    ce |=> peak_cur_q <= $past(max_cur_q) && rated_eff_q <= $past(max_cur_q);
  endproperty
  a_max_clip: assert property (p_max_clip) else $error("peak above max current"); // see [RL12]

  property p_carry_over;
    ce && enable_q && state_q == ST_RATED && !tick_q
      |=> accumulated_load_value_q == $past(accumulated_load_value_q);
  endproperty
  a_carry_over: assert property (p_carry_over) // see [RL13]
    else $error("accumulated load lost");

  property p_decay;
    ce && enable_q && tick_q && meas_current < rated_eff_q
      && accumulated_load_value_q != '0
      |=> accumulated_load_value_q < $past(accumulated_load_value_q);
  endproperty
  a_decay: assert property (p_decay) else $error("load did not decay"); // see [RL14]

  property p_threshold_read;
    ce && rd && addr == OFF_THRESHOLD |=> rdata == $past(threshold_mas_q);
  endproperty
  a_threshold_read: assert property (p_threshold_read) // see [RL4]
    else $error("threshold read wrong");

  property p_applied_read;
    ce && rd && addr == OFF_APPLIED |=> rdata == 32'($past(applied_current_limit));
  endproperty
  a_applied_read: assert property (p_applied_read) // see [RL6]
    else $error("applied limit read wrong");

  property p_grow;
    ce && enable_q && tick_q && meas_current > rated_eff_q
      && accumulated_load_value_q < thermal_load_limit_q
      |=> accumulated_load_value_q > $past(accumulated_load_value_q);
  endproperty
  a_grow: assert property (p_grow) else $error("load did not grow"); // see [RL13]

endmodule
`default_nettype wire

// file: tb/current_loop_model.sv
`default_nettype none
module current_loop_model
  import motor_overload_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [CUR_W-1:0] demand,
  input  wire logic [CUR_W-1:0] limit,
  output var  logic [CUR_W-1:0] meas_current
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Loop settles on the demand, clamped by the applied limit
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meas_current <= '0;
    end else begin
      meas_current <= (demand > limit) ? limit : demand;
    end
  end
endmodule
`default_nettype wire

// file: tb/motor_overload_current_limiter_tb.sv
`default_nettype none
module motor_overload_current_limiter_tb
  import motor_overload_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [CUR_W-1:0]  demand = '0;
  logic [CUR_W-1:0]  meas_current;
  logic [DATA_W-1:0] rdata;
  logic [CUR_W-1:0]  applied_current_limit;
  logic              limiting_active;
  int                failures = 0;
  int                checked = 0;
  int                n1;
  int                n2;

  always #5 clk = ~clk;

  motor_overload_current_limiter #(.TICK_CYCLES(4)) motor_overload_current_limiter_inst (
    .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .meas_current(meas_current), .rdata(rdata),
    .applied_current_limit(applied_current_limit), .limiting_active(limiting_active));

  current_loop_model current_loop_model_inst (
    .clk(clk), .rstn(rstn), .demand(demand), .limit(applied_current_limit),
    .meas_current(meas_current));

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask

  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic wait_lim(input logic [CUR_W-1:0] e, output int n);
    n = 0;
    while (applied_current_limit !== e) begin
      if (n == 300) begin
        failures++;
        final_report();
      end
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 9; i++) chk_reg(8'(i * 4), 32'h0000_0000);
    chk_reg(8'h40, 32'h0000_0000);
    chk("limit port", 32'h0, {16'h0, applied_current_limit});
    $display("test reset done");
  endtask

  task automatic t_enable();
    wr_reg(OFF_MAX_CURRENT, 32'h0000_07D0);
    wr_reg(OFF_RATED_CURRENT, 32'h0000_03E8);
    wr_reg(OFF_PEAK_PERMILLE, 32'h0000_05DC);
    wr_reg(OFF_PEAK_TIME, 32'h0000_000A);
    wr_reg(OFF_SUBMODE, 32'h0000_0001);
    settle();
    chk_reg(OFF_MAX_CURRENT, 32'h0000_07D0);
    chk_reg(OFF_RATED_CURRENT, 32'h0000_03E8);
    chk_reg(OFF_THRESHOLD, 32'h0000_0005);
    chk_reg(OFF_STATUS, 32'h0000_0001);
    @(posedge clk);
    #1;
    chk("rdata idle", 32'h0, rdata);
    chk_reg(OFF_APPLIED, 32'h0000_05DC);
    wr_reg(OFF_THRESHOLD, 32'h0000_0063);
    chk_reg(OFF_THRESHOLD, 32'h0000_0005);
    $display("test enable done");
  endtask

  task automatic t_overload();
    demand <= 16'h07D0;
    wait_lim(16'h03E8, n1);
    chk("first episode", 32'h1, {31'h0, n1 >= 36 && n1 <= 50});
    chk_reg(OFF_ACCUM, 32'h0000_1388);
    chk("status active", 32'h1, {31'h0, limiting_active});
    @(posedge clk);
    ce     <= 1'b0;
    demand <= 16'h01F4;
    repeat (40) @(posedge clk);
    #1;
    chk("frozen limit", 32'h3E8, {16'h0, applied_current_limit});
    @(posedge clk);
    ce <= 1'b1;
    wait_lim(16'h05DC, n2);
    demand <= 16'h07D0;
    wait_lim(16'h03E8, n2);
    chk("second episode", 32'h1, {31'h0, n2 < n1});
    demand <= 16'h0000;
    $display("test overload done");
  endtask

  task automatic t_clip();
    wr_reg(OFF_SUBMODE, 32'h0000_0000);
    wr_reg(OFF_PEAK_PERMILLE, 32'h0000_0BB8);
    settle();
    chk("status off", 32'h0, {31'h0, limiting_active});
    chk("limit off", 32'h7D0, {16'h0, applied_current_limit});
    wr_reg(OFF_SUBMODE, 32'h0000_0001);
    settle();
    chk("limit on", 32'h7D0, {16'h0, applied_current_limit});
    chk_reg(OFF_THRESHOLD, 32'h0000_000A);
    $display("test clip done");
  endtask

  task automatic t_gate();
    wr_reg(OFF_PEAK_PERMILLE, 32'h0000_03E8);
    settle();
    chk("status equal", 32'h0, {31'h0, limiting_active});
    wr_reg(OFF_PEAK_PERMILLE, 32'h0000_05DC);
    wr_reg(OFF_PEAK_TIME, 32'h0000_0000);
    settle();
    chk("status no time", 32'h0, {31'h0, limiting_active});
    wr_reg(OFF_PEAK_TIME, 32'h0000_000A);
    settle();
    chk("status back", 32'h1, {31'h0, limiting_active});
    $display("test gate done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_enable();
    t_overload();
    t_clip();
    t_gate();
    final_report();
  end
endmodule
`default_nettype wire
